// file: rtl/clpl_top.sv
// configuration latch write port and per-channel link fault outputs
`timescale 1ns/10ps
module clpl_top
  import clpl_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                clk_en_i,
  input  wire logic                cfg_write_strobe_n_i,
  input  wire logic [ADDR_W-1:0]   cfg_addr_i,
  input  wire logic [DATA_W-1:0]   cfg_data_i,
  input  wire logic [NUM_CH-1:0]   rate_out_of_range_i,
  input  wire logic [NUM_CH-1:0]   amp_below_level_i,
  input  wire logic [NUM_CH-1:0]   density_low_i,
  input  wire logic [NUM_CH-1:0]   force_local_clock_n_i,
  input  wire logic [NUM_CH-1:0]   training_clock_present_i,
  output logic      [NUM_CH-1:0]   link_fault_n_o,
  output logic      [NUM_CH-1:0]   rx_recovery_pll_use_training_o,
  output logic      [NUM_CH-1:0]   rx_clock_rate_sel_o,
  output logic      [2*NUM_CH-1:0] sig_detect_amp_sel_o,
  output logic      [NUM_CH-1:0]   rx_channel_power_o,
  output logic      [2*NUM_CH-1:0] rx_selftest_ctrl_o
);

  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;
  logic              wr_active;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic [NUM_CH-1:0] rate_bad_s;
  logic [NUM_CH-1:0] amp_low_s;
  logic [NUM_CH-1:0] dens_low_s;
  logic [NUM_CH-1:0] local_clk_s;
  logic [NUM_CH-1:0] trg_absent_s;
  logic              addr_hit;

  // active-low pins are inverted ahead of the synchroniser so reset to
  // zero means idle strobe and no forced local clock
  assign pins_async = {~cfg_write_strobe_n_i,
                       cfg_addr_i,
                       cfg_data_i,
                       rate_out_of_range_i,
                       amp_below_level_i,
                       density_low_i,
                       ~force_local_clock_n_i,
                       ~training_clock_present_i};

  clpl_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .clk_en_i   (clk_en_i),
    .async_i    (pins_async),
    .sync_o     (pins_sync)
  );

  assign {wr_active,
          addr_s,
          data_s,
          rate_bad_s,
          amp_low_s,
          dens_low_s,
          local_clk_s,
          trg_absent_s} = pins_sync;

  // addresses outside the channel latches are ignored
  assign addr_hit = (addr_s >= CH_ADDR_BASE) && (addr_s <= CH_ADDR_LAST);

  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    localparam logic [ADDR_W-1:0] MY_ADDR =
      ADDR_W'(CH_ADDR_BASE + ADDR_W'(ch));

    logic       rate_q;
    logic       rate_d;
    logic [1:0] amp_q;
    logic [1:0] amp_d;
    logic       pwr_q;
    logic       pwr_d;
    logic [1:0] bist_q;
    logic [1:0] bist_d;
    logic       lfn_q;
    logic       lfn_d;
    logic       wr_sel;
    logic       fault_any;

    // latch follows address and data for as long as the strobe is low
    assign wr_sel = clk_en_i && wr_active && addr_hit &&
                    (addr_s == MY_ADDR);                        // [R3] [R4] [R6]

    always_comb
    begin
      rate_d = rate_q;
      amp_d  = amp_q;
      pwr_d  = pwr_q;
      bist_d = bist_q;
      if (wr_sel)
      begin
        rate_d = data_s[RATE_BIT];                              // [R3]
        amp_d  = data_s[AMP_LSB +: 2];
        pwr_d  = data_s[PWR_BIT];
        bist_d = data_s[BIST_LSB +: 2];
      end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        rate_q <= RATE_RST;                                     // [R5]
        amp_q  <= AMP_RST;                                      // [R5]
        pwr_q  <= PWR_RST;                                      // [R5]
        bist_q <= BIST_RST;                                     // [R5]
      end
      else
      begin
        rate_q <= rate_d;
        amp_q  <= amp_d;
        pwr_q  <= pwr_d;
        bist_q <= bist_d;
      end
    end

    // six fault conditions; a powered-down channel counts as disabled
    assign fault_any = rate_bad_s[ch] | amp_low_s[ch] | dens_low_s[ch] |
                       ~pwr_q | local_clk_s[ch] |              // [R1] [R7]
                       trg_absent_s[ch];

    always_comb
    begin
      lfn_d = lfn_q;
      if (clk_en_i)
      begin
        lfn_d = ~fault_any;                                     // [R2]
      end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        lfn_q <= LFN_RST;
      end
      else
      begin
        lfn_q <= lfn_d;
      end
    end

    assign link_fault_n_o[ch]                 = lfn_q;
    assign rx_recovery_pll_use_training_o[ch] = local_clk_s[ch]; // [R7]
    assign rx_clock_rate_sel_o[ch]            = rate_q;
    assign sig_detect_amp_sel_o[2*ch +: 2]    = amp_q;
    assign rx_channel_power_o[ch]             = pwr_q;
    assign rx_selftest_ctrl_o[2*ch +: 2]      = bist_q;
  end

endmodule : clpl_top

// file: rtl/clpl_pkg.sv
// constants for the configuration latch port and link fault block
// Summary of operation
// R1 - each channel fault combines rate, amplitude, density, disable, local clock, training clock
// R2 - link_fault_n is low if any condition holds, high only when none holds
// R3 - a write strobe stores the data bus into the latch chosen by the address
// R4 - configuration uses a four-bit address bus and an eight-bit data bus
// R5 - reset loads every configuration latch with its initialization value
// R6 - strobe is active low; latch follows held address and data while low
// R7 - force_local_clock_n low makes the PLL follow training clock, fault low
package clpl_pkg;

  localparam int unsigned NUM_CH  = 4;
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned SYNC_W  = 1 + ADDR_W + DATA_W + 5 * NUM_CH;

  // each channel's latches sit at address base + channel index
  localparam logic [ADDR_W-1:0] CH_ADDR_BASE = 4'h0;
  localparam logic [ADDR_W-1:0] CH_ADDR_LAST = 4'h3;

  // field positions inside a channel's data byte
  localparam int unsigned RATE_BIT = 0;
  localparam int unsigned AMP_LSB  = 1;
  localparam int unsigned PWR_BIT  = 3;
  localparam int unsigned BIST_LSB = 4;

  // initialization values taken on reset
  localparam logic       RATE_RST = 1'h0;
  localparam logic [1:0] AMP_RST  = 2'h0;
  localparam logic       PWR_RST  = 1'h1;
  localparam logic [1:0] BIST_RST = 2'h3;
  localparam logic       LFN_RST  = 1'h0;

endpackage : clpl_pkg

// file: rtl/clpl_sync.sv
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module clpl_sync
  import clpl_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = clk_en_i ? async_i : meta_q;
    sync_d = clk_en_i ? meta_q : sync_q;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : clpl_sync

// file: testbench/clpl_assertions.sv
// checker for the config latch port and link fault outputs
`timescale 1ns/10ps
module clpl_assertions
  import clpl_pkg::*;
(
  input wire logic                core_clk_i,
  input wire logic                rst_i,
  input wire logic                cfg_write_strobe_n_i,
  input wire logic [ADDR_W-1:0]   cfg_addr_i,
  input wire logic [DATA_W-1:0]   cfg_data_i,
  input wire logic [NUM_CH-1:0]   rate_out_of_range_i,
  input wire logic [NUM_CH-1:0]   amp_below_level_i,
  input wire logic [NUM_CH-1:0]   density_low_i,
  input wire logic [NUM_CH-1:0]   force_local_clock_n_i,
  input wire logic [NUM_CH-1:0]   training_clock_present_i,
  input wire logic [NUM_CH-1:0]   link_fault_n_o,
  input wire logic [NUM_CH-1:0]   rx_recovery_pll_use_training_o,
  input wire logic [NUM_CH-1:0]   rx_channel_power_o,
  input wire logic [2*NUM_CH-1:0] rx_selftest_ctrl_o
);
  logic [1:0]        up_q;
  logic [NUM_CH-1:0] cond;
  assign cond = rate_out_of_range_i | amp_below_level_i | density_low_i
    | ~force_local_clock_n_i | ~training_clock_present_i;
  // counts edges since reset so pin history is post-release
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  fault_eq_a: assert property (up_q == 2'h3 |->
    link_fault_n_o == ~($past(cond, 3) | ~$past(rx_channel_power_o)))
    else $error("fault output wrong");
  local_clk_a: assert property (up_q == 2'h3 |->
    (link_fault_n_o & ~$past(force_local_clock_n_i, 3)) == '0)
    else $error("fault high with local clock");
  pll_follow_a: assert property (up_q > 2'h1 |->
    rx_recovery_pll_use_training_o == ~$past(force_local_clock_n_i, 2))
    else $error("pll select wrong");
  power_off_a: assert property (
    (link_fault_n_o & ~$past(rx_channel_power_o)) == '0)
    else $error("fault high on disabled channel");
  rst_init_a: assert property ($fell(rst_i) |->
    link_fault_n_o == {NUM_CH{LFN_RST}} &&
    rx_channel_power_o == {NUM_CH{PWR_RST}} &&
    rx_selftest_ctrl_o == {NUM_CH{BIST_RST}}) else $error("bad reset value");
  write_pwr_a: assert property (up_q == 2'h3 &&
    !$past(cfg_write_strobe_n_i, 3) && $past(cfg_addr_i, 3) <= CH_ADDR_LAST
    |-> rx_channel_power_o[$past(cfg_addr_i, 3)] ==
    $past(cfg_data_i[PWR_BIT], 3)) else $error("power latch not written");
  write_bist_a: assert property (up_q == 2'h3 &&
    !$past(cfg_write_strobe_n_i, 3) && $past(cfg_addr_i, 3) <= CH_ADDR_LAST
    |-> rx_selftest_ctrl_o[2*$past(cfg_addr_i, 3) +: 2] ==
    $past(cfg_data_i[BIST_LSB+:2], 3)) else $error("self test not written");
  no_write_a: assert property (up_q == 2'h3 &&
    ($past(cfg_write_strobe_n_i, 3) || $past(cfg_addr_i, 3) > CH_ADDR_LAST)
    |-> $stable(rx_channel_power_o) && $stable(rx_selftest_ctrl_o))
    else $error("latch changed without write");
endmodule : clpl_assertions

bind clpl_top clpl_assertions u_chk (.*);

// file: testbench/clpl_host.sv
// host model driving the configuration write port
`timescale 1ns/10ps
module clpl_host
  import clpl_pkg::*;
(
  input  wire logic              core_clk_i,
  output logic                   cfg_write_strobe_n_o,
  output logic      [ADDR_W-1:0] cfg_addr_o,
  output logic      [DATA_W-1:0] cfg_data_o
);
  // released pins settle at the pull-up level
  initial {cfg_write_strobe_n_o, cfg_addr_o, cfg_data_o} = '1;
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_i) #2;
    {cfg_addr_o, cfg_data_o} = {a, d};
    cfg_write_strobe_n_o = 1'b0;
    repeat (3) @(posedge core_clk_i);
    #2 {cfg_write_strobe_n_o, cfg_addr_o, cfg_data_o} = '1;
    repeat (3) @(posedge core_clk_i);
  endtask : write
endmodule : clpl_host

// file: testbench/clpl_top_tb.sv
// self-checking bench for the config latch port and link fault block
`timescale 1ns/10ps
module clpl_top_tb
  import clpl_pkg::*;
;
  logic                   core_clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   wr_n;
  logic [ADDR_W-1:0]      addr;
  logic [DATA_W-1:0]      data;
  logic [4:0][NUM_CH-1:0] cnd = '0;
  logic [NUM_CH-1:0]      fault_n, use_trn, rate, pwr;
  logic [2*NUM_CH-1:0]    amp, bist;
  int                     n_checks = 0;
  int                     n_mismatch = 0;
  int                     cyc = 0;
  clpl_host u_host (.core_clk_i(core_clk_i), .cfg_write_strobe_n_o(wr_n),
    .cfg_addr_o(addr), .cfg_data_o(data));
  clpl_top u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(1'b1),
    .cfg_write_strobe_n_i(wr_n), .cfg_addr_i(addr), .cfg_data_i(data),
    .rate_out_of_range_i(cnd[0]), .amp_below_level_i(cnd[1]),
    .density_low_i(cnd[2]), .force_local_clock_n_i(~cnd[3]),
    .training_clock_present_i(~cnd[4]), .link_fault_n_o(fault_n),
    .rx_recovery_pll_use_training_o(use_trn), .rx_clock_rate_sel_o(rate),
    .sig_detect_amp_sel_o(amp), .rx_channel_power_o(pwr),
    .rx_selftest_ctrl_o(bist));
  initial forever #25 core_clk_i = ~core_clk_i;
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic t_reset();
    chk(fault_n, {NUM_CH{LFN_RST}});
    chk(pwr, {NUM_CH{PWR_RST}});
    chk(bist, {NUM_CH{BIST_RST}});
    chk(rate, {NUM_CH{RATE_RST}});
    chk(amp, {NUM_CH{AMP_RST}});
  endtask : t_reset
  task automatic t_write();
    logic [7:0] d;
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      d = 8'hc0 | 8'(ch * 8'h15);
      u_host.write(4'(ch), d);
      #2 chk(rate[ch], d[RATE_BIT]);
      chk(amp[2*ch+:2], d[AMP_LSB+:2]);
      chk(pwr[ch], d[PWR_BIT]);
      chk(bist[2*ch+:2], d[BIST_LSB+:2]);
    end
    // unmapped address must leave the self-test and power latches alone
    u_host.write(4'h9, 8'h00);
    #2 chk(bist, 8'he4);
    chk(fault_n, 8'h0c);
  endtask : t_write
  task automatic t_fault();
    logic [3:0] e;
    for (int ch = 0; ch < NUM_CH; ch++)
      u_host.write(4'(ch), 8'h08);
    #2;
    for (int i = 0; i < 5; i++)
    begin
      cnd[i] = 4'h1 << (i % NUM_CH);
      repeat (4) @(posedge core_clk_i);
      e = ~cnd[i];
      #2 chk(fault_n, e);
      chk(use_trn, i == 3 ? cnd[3] : 4'h0);
      cnd[i] = 4'h0;
    end
  endtask : t_fault
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    #2;
    t_reset();
    rst_i = 1'b0;
    t_write();
    t_fault();
    test_done();
  end
endmodule : clpl_top_tb
